/* logic/pcer_error_reporter.sv */
// Controller that drives the error-report port of a PCI Express core.
// Assumes the core's report outputs share clk; software uses classic Wishbone.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - Core drops unsupported-request and abort reports while completion-ready is low.
// RULE2 - Non-posted unsupported-request or abort is reported only while completion-ready is high.
// RULE3 - Posted qualifier with a report marks the transaction posted.
// RULE4 - Locked qualifier with a report marks the transaction locked.
// RULE5 - Legacy mode: locked unsupported-request or abort yields a locked completion.
// RULE6 - Outside legacy mode the core makes locked completions on its own.
// RULE7 - No-recovery with poison or timeout keeps the error from being advisory.
// RULE8 - Completion header holds lower address, byte count, traffic class at the top.
// RULE9 - Completion header also holds attributes, requester identifier and tag.
// RULE10 - Corrected internal report counts only with advanced reporting enabled.
// RULE11 - Uncorrectable internal report counts only with advanced reporting enabled.
// RULE12 - Poisoned reports only when automatic poison response is disabled.
// RULE13 - Core flags when its header log is occupied and a header is unneeded.
// RULE14 - A 128-bit header log value accompanies each reported error.
// RULE15 - Core copies the message number into its root error status.
// RULE16 - Message number is driven to suit the enabled interrupt mode.
// RULE17 - Dedicated inputs report timeout, unexpected, correctable, atomic, malformed, multicast.
// RULE18 - A dedicated input reports an end-to-end CRC failure.
// RULE19 - A dedicated input reports an access control violation.
// RULE20 - No-recovery poison stops normal operation; no-recovery timeout need not retry.
// RULE21 - Each report is a one-cycle pulse with qualifiers and headers valid alongside.
// RULE22 - Interrupt request is held until interrupt-ready answers it.
module pcer_error_reporter
  import pcer_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [AW-1:0] wbAdr,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic reportEcrc,
  output logic reportUnsupportedRequest,
  output logic reportCplTimeout,
  output logic reportCplUnexpected,
  output logic reportCplAbort,
  output logic reportCorrectable,
  output logic reportAtomicBlocked,
  output logic reportInternalCor,
  output logic reportInternalUncor,
  output logic reportMalformed,
  output logic reportMulticastBlocked,
  output logic reportPoisoned,
  output logic reportAcs,
  output logic qualPosted,
  output logic qualLocked,
  output logic qualNoRecovery,
  output logic [47:0] cplHeader,
  output logic [127:0] aerHeaderLog,
  output logic [MSG_W-1:0] aerMsgNum,
  output logic intReq,
  output logic haltOperation,
  input wire logic cplRdy,
  input wire logic headerLogSet,
  input wire logic intRdy
);
  pcer_state_e state;
  pcer_state_e next_state;
  logic access;
  logic wrEn;
  logic [7:0] addr;
  logic [31:0] ctrl;
  logic [31:0] cmdWord;
  logic [3:0] cmdType;
  logic cmdPosted;
  logic cmdLocked;
  logic cmdNoRec;
  logic [NUM_ERR-1:0] report;
  logic [NUM_STICKY-1:0] stickySet;
  logic [NUM_STICKY-1:0] stickyClr;
  logic [NUM_STICKY-1:0] sticky;
  logic cmdWrite;
  logic refuse;
  logic needsRdy;
  logic fireOk;
  logic [31:0] readValue;
  logic [3:0] newType;

  pcer_wb_port pcer_wb_port_inst (
    .clk(clk),
    .rstn(rstn),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbAck(wbAck),
    .access(access)
  );

  pcer_sticky #(.W(NUM_STICKY)) pcer_sticky_inst (
    .clk(clk),
    .rstn(rstn),
    .set(stickySet),
    .clr(stickyClr),
    .flags(sticky)
  );

  assign addr = 8'(wbAdr);
  assign wrEn = access && wbWe;
  assign cmdWrite = wrEn && addr == ADDR_CMD && wbSel[0];
  assign newType = wbDatI[CMD_TYPE_LSB +: CMD_TYPE_W];

  // Refuse rather than send reports the core would drop or misread
  always_comb begin
    refuse = state != ST_IDLE || haltOperation || newType > CMD_INTERRUPT;
    if ((newType == ERR_INT_COR || newType == ERR_INT_UNCOR) && !ctrl[CTRL_AER_BIT]) begin
      refuse = 1'b1; // RULE10 RULE11
    end
    if (newType == ERR_POISON && !ctrl[CTRL_ATTR_BIT]) begin
      refuse = 1'b1; // RULE12
    end
  end

  assign needsRdy = (cmdType == ERR_UR || cmdType == ERR_ABORT) && !cmdPosted;
  assign fireOk = !needsRdy || cplRdy; // RULE2

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (cmdWrite && !refuse) begin
          next_state = newType == CMD_INTERRUPT ? ST_INTR : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (fireOk) begin
          next_state = ST_FIRE;
        end
      end
      ST_FIRE: begin
        // Ready fell during the pulse, so the core dropped it: send again
        next_state = fireOk ? ST_IDLE : ST_WAIT; // RULE1
      end
      ST_INTR: begin
        if (intRdy) begin
          next_state = ST_IDLE; // RULE22
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Command latch; locked only in legacy mode since the core handles it otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmdWord <= 32'h0000_0000;
      cmdType <= 4'h0;
      cmdPosted <= 1'b0;
      cmdLocked <= 1'b0;
      cmdNoRec <= 1'b0;
    end else if (cmdWrite && !refuse) begin
      cmdWord <= wbDatI;
      cmdType <= newType;
      cmdPosted <= wbDatI[CMD_POSTED_BIT];
      cmdLocked <= wbDatI[CMD_LOCKED_BIT] && ctrl[CTRL_LEGACY_BIT]; // RULE5 RULE6
      cmdNoRec <= wbDatI[CMD_NOREC_BIT] && (newType == ERR_POISON || newType == ERR_TIMEOUT); // RULE7
    end
  end

  // One-cycle report pulse with its qualifiers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      report <= '0;
      qualPosted <= 1'b0;
      qualLocked <= 1'b0;
      qualNoRecovery <= 1'b0;
    end else if (state == ST_WAIT && fireOk) begin
      report <= NUM_ERR'(1) << cmdType; // RULE17 RULE18 RULE19 RULE21
      qualPosted <= cmdPosted; // RULE3
      qualLocked <= cmdLocked; // RULE4
      qualNoRecovery <= cmdNoRec;
    end else begin
      report <= '0;
      qualPosted <= 1'b0;
      qualLocked <= 1'b0;
      qualNoRecovery <= 1'b0;
    end
  end

  assign reportEcrc = report[ERR_ECRC];
  assign reportUnsupportedRequest = report[ERR_UR];
  assign reportCplTimeout = report[ERR_TIMEOUT];
  assign reportCplUnexpected = report[ERR_UNEXPECT];
  assign reportCplAbort = report[ERR_ABORT];
  assign reportCorrectable = report[ERR_COR];
  assign reportAtomicBlocked = report[ERR_ATOMIC];
  assign reportInternalCor = report[ERR_INT_COR];
  assign reportInternalUncor = report[ERR_INT_UNCOR];
  assign reportMalformed = report[ERR_MALFORMED];
  assign reportMulticastBlocked = report[ERR_MCAST];
  assign reportPoisoned = report[ERR_POISON];
  assign reportAcs = report[ERR_ACS];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      intReq <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_INTR) begin
      intReq <= 1'b1;
    end else if (state == ST_INTR && intRdy) begin
      intReq <= 1'b0; // RULE22
    end
  end

  // A poisoned report that cannot be recovered ends operation until reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      haltOperation <= 1'b0;
    end else if (state == ST_FIRE && fireOk && reportPoisoned && qualNoRecovery) begin
      haltOperation <= 1'b1; // RULE20
    end
  end

  // Control register and message number
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      aerMsgNum <= '0;
    end else begin
      if (wrEn && addr == ADDR_CTRL) begin
        ctrl <= pcer_merge(ctrl, wbDatI, wbSel) & CTRL_MASK;
      end
      aerMsgNum <= ctrl[CTRL_MSG_LSB +: MSG_W]; // RULE16
    end
  end

  // Headers are frozen while a report is in flight so they stay valid with it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cplHeader <= '0;
      aerHeaderLog <= '0;
    end else if (wrEn && state == ST_IDLE) begin
      if (addr == ADDR_CPL_LO) begin
        cplHeader[31:0] <= pcer_merge(cplHeader[31:0], wbDatI, wbSel); // RULE8 RULE9
      end
      if (addr == ADDR_CPL_HI) begin
        cplHeader[47:32] <= 16'(pcer_merge({16'h0000, cplHeader[47:32]}, wbDatI, wbSel));
      end
      if (addr >= ADDR_HLOG0 && addr <= ADDR_HLOG3 && addr[1:0] == 2'b00) begin
        aerHeaderLog[addr[3:2]*32 +: 32] <=
          pcer_merge(aerHeaderLog[addr[3:2]*32 +: 32], wbDatI, wbSel); // RULE14
      end
    end
  end

  assign stickySet[0] = state == ST_FIRE && fireOk || state == ST_INTR && intRdy;
  assign stickySet[1] = cmdWrite && refuse;
  assign stickySet[2] = headerLogSet; // RULE13
  assign stickyClr = (wrEn && addr == ADDR_STATUS && wbSel[1]) ?
    wbDatI[ST_DONE_BIT +: NUM_STICKY] : '0;

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (1'b1)
      addr == ADDR_CTRL: readValue = ctrl;
      addr == ADDR_CMD: readValue = cmdWord;
      addr == ADDR_STATUS: begin
        readValue[ST_BUSY_BIT] = state != ST_IDLE;
        readValue[ST_CPLRDY_BIT] = cplRdy;
        readValue[ST_HALT_BIT] = haltOperation;
        readValue[ST_DONE_BIT +: NUM_STICKY] = sticky;
      end
      addr == ADDR_CPL_LO: readValue = cplHeader[31:0];
      addr == ADDR_CPL_HI: readValue = {16'h0000, cplHeader[47:32]};
      addr >= ADDR_HLOG0 && addr <= ADDR_HLOG3 && addr[1:0] == 2'b00:
        readValue = aerHeaderLog[addr[3:2]*32 +: 32];
      default: readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wbDatO <= 32'h0000_0000;
    end else if (access && !wbWe) begin
      wbDatO <= readValue;
    end
  end

  // Checks
  a_ur_needs_rdy: assert property (@(posedge clk) disable iff (!rstn)
    (reportUnsupportedRequest || reportCplAbort) && !qualPosted |-> $past(cplRdy)) // RULE2
    else $error("non-posted UR or abort without completion ready");
  a_pulse_single: assert property (@(posedge clk) disable iff (!rstn)
    report != '0 |=> report == '0) // RULE21
    else $error("report longer than one cycle");
  a_report_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $onehot0(report)) // RULE17
    else $error("more than one report at once");
  a_posted_match: assert property (@(posedge clk) disable iff (!rstn)
    report != '0 |-> qualPosted == cmdPosted) // RULE3
    else $error("posted qualifier mismatch");
  a_locked_legacy: assert property (@(posedge clk) disable iff (!rstn)
    qualLocked |-> ctrl[CTRL_LEGACY_BIT] && report != '0) // RULE4
    else $error("locked qualifier outside legacy report");
  a_norec_scope: assert property (@(posedge clk) disable iff (!rstn)
    qualNoRecovery |-> reportPoisoned || reportCplTimeout) // RULE20
    else $error("no-recovery on wrong report");
  a_poison_attr: assert property (@(posedge clk) disable iff (!rstn)
    reportPoisoned |-> ctrl[CTRL_ATTR_BIT]) // RULE12
    else $error("poison reported with automatic response on");
  a_hdr_stable: assert property (@(posedge clk) disable iff (!rstn)
    report != '0 |-> $stable(cplHeader) && $stable(aerHeaderLog)) // RULE8
    else $error("headers changed with report");
  a_int_hold: assert property (@(posedge clk) disable iff (!rstn)
    intReq && !intRdy |=> intReq) // RULE22
    else $error("interrupt request dropped early");
  a_msg_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 aerMsgNum == $past(ctrl[CTRL_MSG_LSB +: MSG_W])) // RULE16
    else $error("message number not following control");
  c_ur_fire: cover property (@(posedge clk) disable iff (!rstn)
    reportUnsupportedRequest && !qualPosted);
  c_retry: cover property (@(posedge clk) disable iff (!rstn)
    state == ST_FIRE ##1 state == ST_WAIT);
  c_int_done: cover property (@(posedge clk) disable iff (!rstn) intReq && intRdy);
  c_halt: cover property (@(posedge clk) disable iff (!rstn) $rose(haltOperation));
endmodule
`default_nettype wire

/* logic/pcer_pkg.sv */
// Constants, register map and types for the error report controller.
// Assumes one clock shared with the core's user clock.
`default_nettype none
package pcer_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_HLOG0 = 8'h10;
  localparam logic [7:0] ADDR_HLOG3 = 8'h1C;
  localparam logic [7:0] ADDR_CPL_LO = 8'h20;
  localparam logic [7:0] ADDR_CPL_HI = 8'h24;
  // Control fields
  localparam int CTRL_AER_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;
  localparam int CTRL_ATTR_BIT = 2;
  localparam int CTRL_MSG_LSB = 8;
  localparam int MSG_W = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1F07;
  // Command fields
  localparam int CMD_TYPE_LSB = 0;
  localparam int CMD_TYPE_W = 4;
  localparam int CMD_POSTED_BIT = 8;
  localparam int CMD_LOCKED_BIT = 9;
  localparam int CMD_NOREC_BIT = 10;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CPLRDY_BIT = 1;
  localparam int ST_HALT_BIT = 2;
  localparam int ST_DONE_BIT = 8;
  localparam int ST_REFUSED_BIT = 9;
  localparam int ST_HLOGSET_BIT = 10;
  localparam int NUM_STICKY = 3;
  // Command type codes
  localparam int NUM_ERR = 13;
  localparam logic [3:0] ERR_ECRC = 4'h0;
  localparam logic [3:0] ERR_UR = 4'h1;
  localparam logic [3:0] ERR_TIMEOUT = 4'h2;
  localparam logic [3:0] ERR_UNEXPECT = 4'h3;
  localparam logic [3:0] ERR_ABORT = 4'h4;
  localparam logic [3:0] ERR_COR = 4'h5;
  localparam logic [3:0] ERR_ATOMIC = 4'h6;
  localparam logic [3:0] ERR_INT_COR = 4'h7;
  localparam logic [3:0] ERR_INT_UNCOR = 4'h8;
  localparam logic [3:0] ERR_MALFORMED = 4'h9;
  localparam logic [3:0] ERR_MCAST = 4'hA;
  localparam logic [3:0] ERR_POISON = 4'hB;
  localparam logic [3:0] ERR_ACS = 4'hC;
  localparam logic [3:0] CMD_INTERRUPT = 4'hD;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_FIRE = 4'b0100,
    ST_INTR = 4'b1000
  } pcer_state_e;

  // Byte-lane merge of a Wishbone write into a stored word
  function automatic logic [31:0] pcer_merge(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* logic/pcer_wb_port.sv */
// Classic Wishbone slave handshake: one access strobe, ack one cycle later.
// Assumes the master holds its request until it sees ack.
`timescale 1ns/1ns
`default_nettype none
module pcer_wb_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  output logic wbAck,
  output logic access
);
  // Gating with ack keeps a held request from being taken twice
  assign access = wbCyc && wbStb && !wbAck;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= access;
    end
  end
endmodule
`default_nettype wire

/* logic/pcer_sticky.sv */
// Sticky status flags, set by events, cleared by software.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module pcer_sticky #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule
`default_nettype wire

/* sim/pcer_core_model.sv */
// Behavioural model of the core's error-report port.
// Assumes the controller's pulses share clk; the bench steers readiness and log state.
`timescale 1ns/1ns
`default_nettype none
module pcer_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [12:0] reports,
  input wire logic qualPosted,
  input wire logic qualLocked,
  input wire logic qualNoRecovery,
  input wire logic aerOn,
  input wire logic legacy,
  input wire logic [4:0] aerMsgNum,
  input wire logic intReq,
  input wire logic rdyHold,
  input wire logic logFull,
  output logic cplRdy,
  output logic headerLogSet,
  output logic intRdy,
  output logic [7:0] logCount,
  output logic [3:0] lastType,
  output logic [2:0] lastQual,
  output logic lockedCpl,
  output logic [4:0] rootMsgNum
);
  logic [12:0] taken;
  logic [3:0] idx;
  logic [1:0] waitCnt;
  assign cplRdy = !rdyHold;
  assign headerLogSet = logFull;
  // Slow grant: interrupt is answered only after two held cycles
  assign intRdy = intReq && (waitCnt == 2'h2);
  always_comb begin
    taken = reports;
    taken[1] = reports[1] && cplRdy;
    taken[4] = reports[4] && cplRdy;
    taken[7] = reports[7] && aerOn;
    taken[8] = reports[8] && aerOn;
    idx = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (taken[i]) begin
        idx = 4'(i);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitCnt <= 2'h0;
      logCount <= 8'h00;
      lastType <= 4'h0;
      lastQual <= 3'h0;
      lockedCpl <= 1'b0;
      rootMsgNum <= 5'h00;
    end else begin
      waitCnt <= (intReq && !intRdy) ? waitCnt + 2'h1 : 2'h0;
      rootMsgNum <= aerMsgNum;
      if (|taken) begin
        logCount <= logCount + 8'h01;
        lastType <= idx;
        lastQual <= {qualNoRecovery && (idx == 4'h2 || idx == 4'hB), qualLocked, qualPosted};
        lockedCpl <= legacy && qualLocked && (idx == 4'h1 || idx == 4'h4);
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_pcer_error_reporter.sv */
// Self-checking bench for the error report controller.
// Assumes the core model in pcer_core_model; the watchdog bounds every wait.
`timescale 1ns/1ns
`default_nettype none
module tb_pcer_error_reporter;
  import pcer_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [3:0] wbSel = 4'hF;
  logic aerOn = 1'b0;
  logic legacy = 1'b0;
  logic rdyHold = 1'b0;
  logic logFull = 1'b0;
  logic [31:0] wbDatO;
  logic wbAck, qualPosted, qualLocked, qualNoRecovery, intReq, haltOperation;
  logic cplRdy, headerLogSet, intRdy, lockedCpl;
  wire logic [12:0] rep;
  logic [47:0] cplHeader;
  logic [127:0] aerHeaderLog;
  logic [4:0] aerMsgNum, rootMsgNum;
  logic [7:0] logCount;
  logic [3:0] lastType;
  logic [2:0] lastQual;
  int bad_count = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  pcer_error_reporter pcer_error_reporter_inst (.clk(clk), .rstn(rstn), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbSel(wbSel),
    .wbDatO(wbDatO), .wbAck(wbAck), .reportEcrc(rep[0]), .reportUnsupportedRequest(rep[1]),
    .reportCplTimeout(rep[2]), .reportCplUnexpected(rep[3]), .reportCplAbort(rep[4]),
    .reportCorrectable(rep[5]), .reportAtomicBlocked(rep[6]), .reportInternalCor(rep[7]),
    .reportInternalUncor(rep[8]), .reportMalformed(rep[9]), .reportMulticastBlocked(rep[10]),
    .reportPoisoned(rep[11]), .reportAcs(rep[12]), .qualPosted(qualPosted),
    .qualLocked(qualLocked), .qualNoRecovery(qualNoRecovery), .cplHeader(cplHeader),
    .aerHeaderLog(aerHeaderLog), .aerMsgNum(aerMsgNum), .intReq(intReq),
    .haltOperation(haltOperation), .cplRdy(cplRdy), .headerLogSet(headerLogSet),
    .intRdy(intRdy));
  pcer_core_model pcer_core_model_inst (.clk(clk), .rstn(rstn), .reports(rep),
    .qualPosted(qualPosted), .qualLocked(qualLocked), .qualNoRecovery(qualNoRecovery),
    .aerOn(aerOn), .legacy(legacy), .aerMsgNum(aerMsgNum), .intReq(intReq),
    .rdyHold(rdyHold), .logFull(logFull), .cplRdy(cplRdy), .headerLogSet(headerLogSet),
    .intRdy(intRdy), .logCount(logCount), .lastType(lastType), .lastQual(lastQual),
    .lockedCpl(lockedCpl), .rootMsgNum(rootMsgNum));
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; read data is taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    wbAdr <= a;
    wbDatI <= d;
    wbWe <= we;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    // No answer time is assumed; a missing ack is left to the watchdog
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while (s[ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (n >= 40) bad_count++;
  endtask
  task automatic cmd(input logic [3:0] ty, input logic [2:0] q);
    wr(ADDR_CMD, {21'h00_0000, q, 4'h0, ty});
    wait_idle();
  endtask
  task automatic set_ctrl(input logic [31:0] c);
    aerOn <= c[CTRL_AER_BIT];
    legacy <= c[CTRL_LEGACY_BIT];
    wr(ADDR_CTRL, c);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    rd(ADDR_CTRL, q);
    check("ctrl", q, CTRL_RESET);
    rd(ADDR_STATUS, q);
    check("status", q, 32'h0000_0002);
    rd(8'h40, q);
    check("unmapped", q, 32'h0000_0000);
  endtask
  task automatic t_types();
    logic [7:0] c0;
    set_ctrl(32'h0000_0005);
    for (int i = 0; i < NUM_ERR; i++) begin
      c0 = logCount;
      cmd(4'(i), 3'h0);
      check("type", {28'h000_0000, lastType}, i);
      check("count", logCount, c0 + 8'h01);
    end
  endtask
  // Each refusal is checked alone, so the sticky bit is cleared after it
  task automatic refused_cmd(input logic [31:0] c, input logic [3:0] ty);
    logic [31:0] s;
    set_ctrl(c);
    cmd(ty, 3'h0);
    rd(ADDR_STATUS, s);
    check("refused", s[ST_REFUSED_BIT], 1'b1);
    wr(ADDR_STATUS, 32'h0000_0200);
  endtask
  task automatic t_refuse();
    logic [7:0] c0;
    c0 = logCount;
    refused_cmd(32'h0000_0004, ERR_INT_COR);
    refused_cmd(32'h0000_0004, ERR_INT_UNCOR);
    refused_cmd(32'h0000_0001, ERR_POISON);
    refused_cmd(32'h0000_0005, 4'hE);
    check("count", logCount, c0);
  endtask
  task automatic t_ready();
    logic [31:0] s;
    logic [7:0] c0;
    c0 = logCount;
    rdyHold <= 1'b1;
    wr(ADDR_CMD, {28'h000_0000, ERR_UR});
    repeat (10) @(posedge clk);
    rd(ADDR_STATUS, s);
    check("held busy", s[ST_BUSY_BIT], 1'b1);
    check("held count", logCount, c0);
    rdyHold <= 1'b0;
    wait_idle();
    check("ur sent", logCount, c0 + 8'h01);
    // Ready drops in the pulse cycle: the core drops it and it must be resent
    rdyHold <= 1'b1;
    wr(ADDR_CMD, {28'h000_0000, ERR_ABORT});
    rdyHold <= 1'b0;
    @(posedge clk);
    rdyHold <= 1'b1;
    @(posedge clk);
    rdyHold <= 1'b0;
    wait_idle();
    check("resent", logCount, c0 + 8'h02);
  endtask
  task automatic t_quals();
    set_ctrl(32'h0000_0007);
    cmd(ERR_UR, 3'b010);
    check("locked q", lastQual, 3'b010);
    check("locked cpl", lockedCpl, 1'b1);
    set_ctrl(32'h0000_0005);
    cmd(ERR_ABORT, 3'b010);
    check("no lock", {lockedCpl, lastQual}, 4'h0);
    cmd(ERR_ECRC, 3'b001);
    check("posted", lastQual, 3'b001);
    cmd(ERR_TIMEOUT, 3'b100);
    check("norec to", lastQual, 3'b100);
    cmd(ERR_COR, 3'b100);
    check("norec cor", lastQual, 3'b000);
    check("no halt", haltOperation, 1'b0);
  endtask
  task automatic t_headers();
    wr(ADDR_CPL_LO, 32'h89AB_CDEF);
    wr(ADDR_CPL_HI, 32'h0000_FE01);
    check("cpl lo", cplHeader[31:0], 32'h89AB_CDEF);
    check("cpl hi", cplHeader[47:32], 16'hFE01);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_HLOG0 + 8'(4 * i), 32'h1111_1111 * (i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      check("hlog", aerHeaderLog[i*32 +: 32], 32'h1111_1111 * (i + 1));
    end
  endtask
  task automatic t_logset_int();
    logic [31:0] s;
    logFull <= 1'b1;
    @(posedge clk);
    logFull <= 1'b0;
    rd(ADDR_STATUS, s);
    check("logset", s[ST_HLOGSET_BIT], 1'b1);
    wr(ADDR_STATUS, 32'h0000_0700);
    rd(ADDR_STATUS, s);
    check("w1c", s[10:8], 3'h0);
    set_ctrl(32'h0000_1505);
    repeat (2) @(posedge clk);
    check("msgnum", aerMsgNum, 5'h15);
    check("root msg", rootMsgNum, 5'h15);
    wr(ADDR_CMD, {28'h000_0000, CMD_INTERRUPT});
    check("int held", intReq, 1'b1);
    wait_idle();
    rd(ADDR_STATUS, s);
    check("int done", {intReq, s[ST_DONE_BIT]}, 2'b01);
  endtask
  task automatic t_halt();
    logic [7:0] c0;
    cmd(ERR_POISON, 3'b100);
    check("halt q", lastQual, 3'b100);
    check("halt", haltOperation, 1'b1);
    c0 = logCount;
    cmd(ERR_COR, 3'h0);
    check("halt stop", logCount, c0);
    // Only a reset lifts the halt
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("halt reset", haltOperation, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_types();
    t_refuse();
    t_ready();
    t_quals();
    t_headers();
    t_logset_int();
    t_halt();
    wrap_up();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
